// [verilog/probe_lock_pkg.sv]
// Constants and types shared by the debug probe protect lock.
// Assumes a 32-bit register port and the single system clock.
package probe_lock_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [31:0] MODE_ADDR = 32'hffffe510;   // Protect mode register
    localparam logic [31:0] KEY_ADDR = 32'hffffe514;    // Write-only protect key register
    localparam logic [31:0] BOOT_ADDR = 32'hffffe518;   // Flash boot mode control
    localparam logic [31:0] STAT_ADDR = 32'hffffe51c;   // Lock and boot status

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DISABLE_POS = 0;     // Probe disable bit in mode register
    localparam int REENABLE_POS = 1;    // Protect re-enable bit in mode register
    localparam int USER_BOOT_POS = 0;   // User boot bit in boot register
    localparam int STAT_LOCK_POS = 0;   // Inhibit state in status register
    localparam int STAT_BOOT_POS = 1;   // User boot state in status register

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [31:0] PROTECT_KEY = 32'h000000c5;  // Only key word accepted
    localparam logic DISABLE_RESET = 1'h1;               // Probe disabled at power-on
    localparam logic REENABLE_RESET = 1'h0;              // Re-enable clear at power-on
    localparam logic USER_BOOT_RESET = 1'h0;             // Flash in normal mode
    localparam logic [31:0] READ_ZERO = 32'h00000000;    // Unmapped and write-only reads

    // ------------------------------------------------------------
    // Lock state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_OPEN = 1'b0,     // Probe allowed
        ST_LOCKED = 1'b1    // Probe inhibited
    } lock_state_t;

    localparam lock_state_t LOCK_RESET = ST_LOCKED;      // Locked after power-on

endpackage : probe_lock_pkg

// [verilog/lock_ctrl_if.sv]
// Interface between register front end and lock state keeper.
// Assumes both ends share clk and the power-on reset.
`timescale 1ns/1ps
interface lock_ctrl_if;
    logic key_ok;                       // One-cycle pulse: correct key written
    logic disable_bit;                  // Current probe disable bit
    logic reenable_bit;                 // Current protect re-enable bit
    probe_lock_pkg::lock_state_t state; // Current lock state

    modport front (output key_ok, output disable_bit, output reenable_bit, input state);
    modport keeper (input key_ok, input disable_bit, input reenable_bit, output state);
endinterface : lock_ctrl_if

// [verilog/lock_keeper.sv]
// Holds the probe inhibit state, changed only by a key commit or a power-on reset.
// Assumes npor is a synchronous active-low power-on reset.
`timescale 1ns/1ps
module lock_keeper (
    input wire logic clk,
    input wire logic npor,
    lock_ctrl_if.keeper ctl
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    probe_lock_pkg::lock_state_t state_reg;   // Inhibit state
    probe_lock_pkg::lock_state_t state_next;  // Its next value

    // Commit on key: re-enable wins over a cleared disable bit
    always_comb begin
        state_next = state_reg;
        if (ctl.key_ok) begin
            if (ctl.reenable_bit) begin
                state_next = probe_lock_pkg::ST_LOCKED;
            end else if (!ctl.disable_bit) begin
                state_next = probe_lock_pkg::ST_OPEN;
            end else begin
                state_next = state_reg;                  // Nothing armed
            end
        end
    end

    // Of the two resets only power-on reset relocks; system reset leaves it alone
    always_ff @(posedge clk) begin
        if (!npor) begin
            state_reg <= probe_lock_pkg::LOCK_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ctl.state = state_reg;

endmodule : lock_keeper

// [verilog/debug_probe_protect_lock.sv]
// Register front end and probe gate of the debug probe protect lock.
// Assumes a plain register port with reads answered one cycle later,
// a synchronous power-on reset npor and a synchronous system reset nrst.
`timescale 1ns/1ps

module debug_probe_protect_lock (
    input wire logic clk,
    input wire logic nrst,
    input wire logic npor,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic probe_flash_req,
    output logic probe_flash_grant,
    output logic probe_enable,
    output logic flash_user_boot
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // Full-word address match
    function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
        hit = (a == target);
    endfunction : hit

    logic sel_mode;     // Mode register addressed
    logic sel_key;      // Key register addressed
    logic sel_boot;     // Boot control addressed
    logic sel_stat;     // Status addressed

    // Decode each register once per cycle
    always_comb begin
        sel_mode = hit(addr, probe_lock_pkg::MODE_ADDR);
        sel_key = hit(addr, probe_lock_pkg::KEY_ADDR);
        sel_boot = hit(addr, probe_lock_pkg::BOOT_ADDR);
        sel_stat = hit(addr, probe_lock_pkg::STAT_ADDR);
    end

    // ------------------------------------------------------------
    // Link to the lock keeper
    // ------------------------------------------------------------
    lock_ctrl_if ctl ();    // Front-to-keeper bundle

    lock_keeper u_keeper (
        .clk(clk),
        .npor(npor),
        .ctl(ctl.keeper)
    );

    // ------------------------------------------------------------
    // Protect mode register
    // ------------------------------------------------------------
    logic disable_reg;      // Probe disable bit
    logic disable_next;     // Its next value
    logic reenable_reg;     // Protect re-enable bit
    logic reenable_next;    // Its next value

    // Full-word write updates both bits; upper bits are dropped
    always_comb begin
        disable_next = disable_reg;
        reenable_next = reenable_reg;
        if (wr && sel_mode) begin
            disable_next = wdata[probe_lock_pkg::DISABLE_POS];
            reenable_next = wdata[probe_lock_pkg::REENABLE_POS];
        end
    end

    // Survives system reset, loaded with DISABLE_RESET and REENABLE_RESET only on power-on
    always_ff @(posedge clk) begin
        if (!npor) begin
            disable_reg <= probe_lock_pkg::DISABLE_RESET;
            reenable_reg <= probe_lock_pkg::REENABLE_RESET;
        end else begin
            disable_reg <= disable_next;
            reenable_reg <= reenable_next;
        end
    end

    // ------------------------------------------------------------
    // Key register commit
    // ------------------------------------------------------------

    // Key word is never stored; only the match pulse leaves here
    always_comb begin
        ctl.key_ok = wr && sel_key && (wdata == probe_lock_pkg::PROTECT_KEY);
        ctl.disable_bit = disable_reg;
        ctl.reenable_bit = reenable_reg;
    end

    // ------------------------------------------------------------
    // Flash boot mode control
    // ------------------------------------------------------------
    logic user_boot_reg;    // Flash in user boot mode
    logic user_boot_next;   // Its next value

    // Software selects user boot after the reset procedure
    always_comb begin
        user_boot_next = user_boot_reg;
        if (wr && sel_boot) begin
            user_boot_next = wdata[probe_lock_pkg::USER_BOOT_POS];
        end
    end

    // Any reset returns the flash to normal mode
    always_ff @(posedge clk) begin
        if (!nrst || !npor) begin
            user_boot_reg <= probe_lock_pkg::USER_BOOT_RESET;
        end else begin
            user_boot_reg <= user_boot_next;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rdata_reg;     // Registered read word
    logic [31:0] rdata_next;    // Its next value

    // Build the read word; everything not listed reads zero
    always_comb begin
        rdata_next = probe_lock_pkg::READ_ZERO;
        if (rd) begin
            if (sel_mode) begin
                // Upper bits of mode register stay zero
                rdata_next[probe_lock_pkg::DISABLE_POS] = disable_reg;
                rdata_next[probe_lock_pkg::REENABLE_POS] = reenable_reg;
            end else if (sel_boot) begin
                rdata_next[probe_lock_pkg::USER_BOOT_POS] = user_boot_reg;
            end else if (sel_stat) begin
                rdata_next[probe_lock_pkg::STAT_LOCK_POS] =
                    (ctl.state == probe_lock_pkg::ST_LOCKED);
                rdata_next[probe_lock_pkg::STAT_BOOT_POS] = user_boot_reg;
            end else begin
                // Key register is write-only; unmapped also zero
                rdata_next = probe_lock_pkg::READ_ZERO;
            end
        end
    end

    // Read word stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!nrst || !npor) begin
            rdata_reg <= probe_lock_pkg::READ_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Probe gate and outputs
    // ------------------------------------------------------------

    // Probe access passes only while unlocked
    always_comb begin
        probe_enable = (ctl.state == probe_lock_pkg::ST_OPEN);
        probe_flash_grant = probe_flash_req && probe_enable;
        rdata = rdata_reg;
        flash_user_boot = user_boot_reg;
    end

endmodule : debug_probe_protect_lock

// [tb/lock_monitor.sv]
// Port checker for the debug probe protect lock.
// Assumes probe_lock_pkg is compiled first; bound to the top module.
`timescale 1ns/1ps
module lock_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic npor,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic probe_flash_req,
    input wire logic probe_flash_grant,
    input wire logic probe_enable,
    input wire logic flash_user_boot
);
    // ------------------------------------------------------------
    // Register write steps
    // ------------------------------------------------------------
    sequence key_wr;
        wr && addr == probe_lock_pkg::KEY_ADDR && wdata == probe_lock_pkg::PROTECT_KEY;
    endsequence
    sequence clear_wr;
        wr && addr == probe_lock_pkg::MODE_ADDR && wdata[1:0] == 2'h0;
    endsequence
    sequence reen_wr;
        wr && addr == probe_lock_pkg::MODE_ADDR && wdata[1];
    endsequence
    default clocking cb @(posedge clk); endclocking
    default disable iff (!npor);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_grant_gate: assert property (probe_flash_grant == (probe_flash_req && probe_enable))
        else $error("grant not gated by probe enable");
    a_unlock_steps: assert property (clear_wr ##1 key_wr |=> probe_enable)
        else $error("clear and key did not open the lock");
    a_relock_steps: assert property (reen_wr ##1 key_wr |=> !probe_enable)
        else $error("re-enable and key did not relock");
    a_lock_hold: assert property (!(wr && addr == probe_lock_pkg::KEY_ADDR
        && wdata == probe_lock_pkg::PROTECT_KEY) |=> $stable(probe_enable))
        else $error("lock changed without key commit");
    a_por_lock: assert property (disable iff (1'b0) !npor |=> !probe_enable)
        else $error("power-on reset left lock open");
    a_boot_normal: assert property (!nrst |=> !flash_user_boot)
        else $error("reset left flash in user boot");
    a_key_rdzero: assert property (rd && addr == probe_lock_pkg::KEY_ADDR |=> rdata == 32'h0)
        else $error("key register read not zero");
    a_mode_upper: assert property (rd && addr == probe_lock_pkg::MODE_ADDR
        |=> rdata[31:2] == 30'h0)
        else $error("mode upper bits not zero");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside read slot");
endmodule : lock_monitor
bind debug_probe_protect_lock lock_monitor lock_monitor_inst (.clk(clk), .nrst(nrst),
    .npor(npor), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .probe_flash_req(probe_flash_req), .probe_flash_grant(probe_flash_grant),
    .probe_enable(probe_enable), .flash_user_boot(flash_user_boot));

// [tb/probe_model.sv]
// External debug probe: raises its flash request on clock edges.
// Assumes the bench says when the probe wants access.
`timescale 1ns/1ps
module probe_model (
    input wire logic clk,
    input wire logic want,
    output logic probe_flash_req
);
    // Request follows intent one cycle later
    always_ff @(posedge clk) begin
        probe_flash_req <= want;
    end
endmodule : probe_model

// [tb/testbench.sv]
// Self-checking bench for the debug probe protect lock.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ps
module testbench;
    logic clk, nrst, npor, wr, rd, want, req, grant, pen, uboot;
    logic [31:0] addr, wdata, rdata;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    debug_probe_protect_lock debug_probe_protect_lock_inst (.clk(clk), .nrst(nrst),
        .npor(npor), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .probe_flash_req(req), .probe_flash_grant(grant), .probe_enable(pen),
        .flash_user_boot(uboot));
    probe_model probe_model_inst (.clk(clk), .want(want), .probe_flash_req(req));
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Full-word write, one cycle
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        rd <= 1'b0;
        wr <= 1'b1;
        @(posedge clk);
    endtask : wr_reg
    // Full-word read, data checked in the following cycle
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        #1;
        chk(rdata & m, e);
    endtask : rd_chk
    task automatic idle();
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
        #1;
    endtask : idle
    task automatic por();
        npor <= 1'b0;
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        npor <= 1'b1;
        nrst <= 1'b1;
    endtask : por
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {nrst, npor, wr, rd, want} = 5'h0;
        addr = 32'h0;
        wdata = 32'h0;
        por();
        rd_chk(probe_lock_pkg::MODE_ADDR, 32'hffffffff, 32'h1);
        want <= 1'b1;
        idle();
        idle();
        chk(grant, 1'b0);
        wr_reg(probe_lock_pkg::MODE_ADDR, 32'h0);
        wr_reg(probe_lock_pkg::KEY_ADDR, 32'hc4);
        idle();
        chk(pen, 1'b0);
        $display("test power-on and wrong key done");
        wr_reg(probe_lock_pkg::MODE_ADDR, 32'h0);
        wr_reg(probe_lock_pkg::KEY_ADDR, 32'hc5);
        idle();
        chk(pen, 1'b1);
        chk(grant, 1'b1);
        rd_chk(probe_lock_pkg::KEY_ADDR, 32'hffffffff, 32'h0);
        rd_chk(probe_lock_pkg::MODE_ADDR, 32'hffffffff, 32'h0);
        $display("test unlock done");
        // User boot entered with no interrupt source in the bench at all
        wr_reg(probe_lock_pkg::BOOT_ADDR, 32'h1);
        rd_chk(probe_lock_pkg::STAT_ADDR, 32'h3, 32'h2);
        nrst <= 1'b0;
        idle();
        nrst <= 1'b1;
        chk(uboot, 1'b0);
        chk(pen, 1'b1);
        rd_chk(probe_lock_pkg::MODE_ADDR, 32'h1, 32'h0);
        $display("test system reset done");
        wr_reg(probe_lock_pkg::MODE_ADDR, 32'h2);
        wr_reg(probe_lock_pkg::KEY_ADDR, 32'hc5);
        idle();
        chk(pen, 1'b0);
        chk(grant, 1'b0);
        rd_chk(32'hffffe520, 32'hffffffff, 32'h0);
        $display("test relock done");
        wr_reg(probe_lock_pkg::MODE_ADDR, 32'h0);
        wr_reg(probe_lock_pkg::KEY_ADDR, 32'hc5);
        idle();
        por();
        idle();
        chk(pen, 1'b0);
        rd_chk(probe_lock_pkg::MODE_ADDR, 32'h1, 32'h1);
        $display("test second power-on done");
        end_sim();
    end
endmodule : testbench
